// file: design/udpg_top.sv
// Operation
// - Endpoint status array at 0x030, data array at 0x050, four-byte stride.
// - Frame number field takes the 11-bit frame at end of packet.
// - Frame error set at end of bad packet, cleared on next PID.
// - Frame good set at end of clean packet, cleared on next PID.
// - Start-of-frame status raised on PID, not waiting for end.
// - Address-state bit: write 1 enters, write 0 ignored, reset leaves.
// - Configured bit enters on 1, leaves on 0, reads back state.
// - Send-resume enable allows remote wakeup and accepts resume pin.
// - Resume-in-progress set when host resumes during remote wakeup.
// - Remote wakeup drive with enable drives K; software clears it.
// - Seven-bit function address, reset zero, written by firmware.
// - Function enable reads back; 0 disables endpoints; 1 allows transfers.
// - Enable register: write 1 sets mask bit, 0 ignored.
// - Disable register: write 1 clears mask bit except bus-reset-end, 0 ignored.
// - Clear register: write 1 clears status flag except endpoint bits, 0 ignored.
// - Three ms without bus activity sets suspend status and suspends.
`timescale 1ns/100ps
`include "udpg_map.svh"

module udpg_top
	import udpg_pkg::*;
#(
	parameter int unsigned IDLE_CYCLES = `UDPG_SUSPEND_IDLE_US * `UDPG_CLK_MHZ,
	parameter int unsigned NUM_EP      = `UDPG_NUM_EP
)(
	input  wire logic              clk_sys,        // System clock, 125 MHz
	input  wire logic              reset_n,        // Async reset, active low
	input  wire logic [7:0]        regAddr,        // Register byte address
	input  wire logic [31:0]       regWdata,       // Write data
	input  wire logic              regWrite,       // Write strobe
	input  wire logic              regRead,        // Read strobe
	output logic      [31:0]       regRdata,       // Read data, cycle after strobe
	input  wire logic              sofPid,         // Start-of-frame PID pulse
	input  wire logic              sofEop,         // Start-of-frame end pulse
	input  wire logic              sofBad,         // Packet error at end
	input  wire logic [10:0]       sofFrame,       // Received frame field
	input  wire logic              busResetEnd,    // End of host bus reset pulse
	input  wire logic              busActivityPin, // Line activity, async
	input  wire logic              sendResumePin,  // External resume, async
	input  wire logic [NUM_EP-1:0] epIrq,          // Endpoint interrupt levels
	input  wire logic [31:0]       epRdata,        // Endpoint register read data
	output logic                   epCsrSel,       // Endpoint status access
	output logic                   epFdrSel,       // Endpoint data access
	output logic [1:0]             epIndex,        // Endpoint number of access
	output logic                   epWrite,        // Endpoint write strobe
	output logic                   epRead,         // Endpoint read strobe
	output logic [31:0]            epWdata,        // Endpoint write data
	output logic [NUM_EP-1:0]      epReset,        // Endpoint reset levels
	output logic                   functionEnable, // Endpoints may transfer
	output logic [6:0]             functionAddr,   // Device address
	output logic                   addressState,   // In address state
	output logic                   configured,     // In configured state
	output logic                   kStateDrive,    // Drive K on the bus
	output logic                   suspended,      // Link suspended
	output logic                   irq             // Interrupt request
);

	udpg_evt_if evt ();

	logic          addrState_r;
	logic          configured_r;
	logic          sendResEn_r;
	logic          resumeInProg_r;
	logic          remoteWake_r;
	logic [6:0]    funcAddr_r;
	logic          funcEn_r;
	udpg_irq_vec_t mask_r;
	logic [13:8]   status_r;
	logic [NUM_EP-1:0] epReset_r;
	logic [31:0]   rdata_r;
	logic [31:0]   rdata_nxt;
	logic          epRange;
	udpg_irq_vec_t statusView;
	udpg_irq_vec_t statusSet;
	udpg_irq_vec_t wrEnable;
	udpg_irq_vec_t wrDisable;
	udpg_irq_vec_t wrClear;

	////////////////////////////////////////////////////////////////////////////
	// Event sources

	udpg_frame_capture u_frame (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.sofPid   (sofPid),
		.sofEop   (sofEop),
		.sofBad   (sofBad),
		.sofFrame (sofFrame),
		.evt      (evt.frame_src)
	);

	udpg_suspend_timer #(
		.IDLE_CYCLES (IDLE_CYCLES)
	) u_susp (
		.clk_sys        (clk_sys),
		.reset_n        (reset_n),
		.busActivityPin (busActivityPin),
		.sendResumePin  (sendResumePin),
		.evt            (evt.susp_src)
	);

	assign evt.sendResumeEnable = sendResEn_r;

	////////////////////////////////////////////////////////////////////////////
	// Endpoint array decode

	always_comb begin
		epCsrSel = (regAddr >= `UDPG_OFS_EP_CSR_BASE)
		           && (regAddr < 8'(`UDPG_OFS_EP_CSR_BASE + 4 * NUM_EP));
		epFdrSel = (regAddr >= `UDPG_OFS_EP_FDR_BASE)
		           && (regAddr < 8'(`UDPG_OFS_EP_FDR_BASE + 4 * NUM_EP));
		epRange  = epCsrSel || epFdrSel;
		epIndex  = epCsrSel ? 2'(regAddr - `UDPG_OFS_EP_CSR_BASE >> 2)
		                    : 2'(regAddr - `UDPG_OFS_EP_FDR_BASE >> 2);
	end

	assign epWrite = regWrite && epRange;
	assign epRead  = regRead && epRange;
	assign epWdata = regWdata;

	////////////////////////////////////////////////////////////////////////////
	// Write strobes for the one-shot registers

	assign wrEnable  = (regWrite && regAddr == `UDPG_OFS_INTERRUPT_ENABLE)
	                   ? (regWdata[13:0] & `UDPG_IRQ_MASKABLE) : 14'h0000;
	assign wrDisable = (regWrite && regAddr == `UDPG_OFS_INTERRUPT_DISABLE)
	                   ? (regWdata[13:0] & `UDPG_IRQ_MASKABLE) : 14'h0000;
	assign wrClear   = (regWrite && regAddr == `UDPG_OFS_INTERRUPT_CLEAR)
	                   ? (regWdata[13:0] & `UDPG_IRQ_CLEARABLE) : 14'h0000;

	////////////////////////////////////////////////////////////////////////////
	// Device state

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			addrState_r <= 1'(`UDPG_RST_GLOBAL_STATE >> `UDPG_BIT_ADDRESS_STATE);
		end else if (regWrite && regAddr == `UDPG_OFS_GLOBAL_STATE
		             && regWdata[`UDPG_BIT_ADDRESS_STATE]) begin
			addrState_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			configured_r <= 1'(`UDPG_RST_GLOBAL_STATE >> `UDPG_BIT_CONFIGURED);
		end else if (regWrite && regAddr == `UDPG_OFS_GLOBAL_STATE) begin
			configured_r <= regWdata[`UDPG_BIT_CONFIGURED];
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sendResEn_r  <= 1'(`UDPG_RST_GLOBAL_STATE >> `UDPG_BIT_SEND_RESUME_EN);
			remoteWake_r <= 1'(`UDPG_RST_GLOBAL_STATE >> `UDPG_BIT_REMOTE_WAKE_DRIVE);
		end else if (regWrite && regAddr == `UDPG_OFS_GLOBAL_STATE) begin
			sendResEn_r  <= regWdata[`UDPG_BIT_SEND_RESUME_EN];
			remoteWake_r <= regWdata[`UDPG_BIT_REMOTE_WAKE_DRIVE];
		end
	end

	// host resume during wakeup
	// Cleared only when software drops the drive bit; a resume in that cycle wins
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			resumeInProg_r <= 1'(`UDPG_RST_GLOBAL_STATE >> `UDPG_BIT_RESUME_IN_PROG);
		end else if (evt.hostResumeEvt && kStateDrive) begin
			resumeInProg_r <= 1'b1;
		end else if (regWrite && regAddr == `UDPG_OFS_GLOBAL_STATE
		             && !regWdata[`UDPG_BIT_REMOTE_WAKE_DRIVE]) begin
			resumeInProg_r <= 1'b0;
		end
	end

	assign kStateDrive = remoteWake_r && sendResEn_r;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			funcAddr_r <= 7'(`UDPG_RST_FUNCTION_ADDRESS);
			funcEn_r   <= 1'(`UDPG_RST_FUNCTION_ADDRESS >> `UDPG_BIT_FUNCTION_ENABLE);
		end else if (regWrite && regAddr == `UDPG_OFS_FUNCTION_ADDRESS) begin
			funcAddr_r <= regWdata[`UDPG_FUNCTION_ADDRESS_VALUE_W-1:0];
			funcEn_r   <= regWdata[`UDPG_BIT_FUNCTION_ENABLE];
		end
	end

	// Held levels; endpoint logic must see them released by software
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			epReset_r <= '0;
		end else if (regWrite && regAddr == `UDPG_OFS_ENDPOINT_RESET) begin
			epReset_r <= regWdata[NUM_EP-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt mask and status

	// disable clears mask
	// Bus-reset-end bit cannot be masked off, so it stays fixed high
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mask_r <= `UDPG_RST_INTERRUPT_MASK;
		end else begin
			mask_r <= ((mask_r | wrEnable) & ~wrDisable) | `UDPG_RST_INTERRUPT_MASK
			          & ~`UDPG_IRQ_MASKABLE;
		end
	end

	always_comb begin
		statusSet = 14'h0000;
		statusSet[`UDPG_BIT_SUSPEND]       = evt.suspendEvt;
		statusSet[`UDPG_BIT_HOST_RESUME]   = evt.hostResumeEvt;
		statusSet[`UDPG_BIT_EXT_RESUME]    = evt.extResumeEvt;
		statusSet[`UDPG_BIT_FRAME_START]   = evt.frameStart;
		statusSet[`UDPG_BIT_BUS_RESET_END] = busResetEnd;
		statusSet[`UDPG_BIT_WAKEUP]        = evt.hostResumeEvt || busResetEnd || evt.extResumeEvt;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			status_r <= 6'h00;
		end else begin
			status_r <= (status_r & ~wrClear[13:8]) | statusSet[13:8];
		end
	end

	// Endpoint bits are live levels; endpoint logic holds them sticky
	assign statusView = {status_r, 4'h0, epIrq};

	assign irq = |(statusView & mask_r);

	////////////////////////////////////////////////////////////////////////////
	// Read path

	always_comb begin
		rdata_nxt = 32'h00000000;
		if (epRange) begin
			rdata_nxt = epRdata;
		end else begin
			unique case (regAddr)
				`UDPG_OFS_FRAME_NUMBER: begin
					rdata_nxt[`UDPG_FRAME_COUNT_FIELD_W-1:0]     = evt.frameCount;
					rdata_nxt[`UDPG_BIT_FRAME_ERROR]   = evt.frameError;
					rdata_nxt[`UDPG_BIT_FRAME_GOOD]    = evt.frameGood;
				end
				`UDPG_OFS_GLOBAL_STATE: begin
					rdata_nxt[`UDPG_BIT_ADDRESS_STATE]     = addrState_r;
					rdata_nxt[`UDPG_BIT_CONFIGURED]        = configured_r;
					rdata_nxt[`UDPG_BIT_SEND_RESUME_EN]    = sendResEn_r;
					rdata_nxt[`UDPG_BIT_RESUME_IN_PROG]    = resumeInProg_r;
					rdata_nxt[`UDPG_BIT_REMOTE_WAKE_DRIVE] = remoteWake_r;
				end
				`UDPG_OFS_FUNCTION_ADDRESS: begin
					rdata_nxt[`UDPG_FUNCTION_ADDRESS_VALUE_W-1:0]         = funcAddr_r;
					rdata_nxt[`UDPG_BIT_FUNCTION_ENABLE] = funcEn_r;
				end
				`UDPG_OFS_INTERRUPT_MASK:   rdata_nxt[13:0] = mask_r;
				`UDPG_OFS_INTERRUPT_STATUS: rdata_nxt[13:0] = statusView;
				`UDPG_OFS_ENDPOINT_RESET:   rdata_nxt[NUM_EP-1:0] = epReset_r;
				default:                    rdata_nxt = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rdata_r <= 32'h00000000;
		end else if (regRead) begin
			rdata_r <= rdata_nxt;
		end else begin
			rdata_r <= 32'h00000000;
		end
	end

	assign regRdata       = rdata_r;
	assign epReset        = epReset_r;
	assign functionEnable = funcEn_r;
	assign functionAddr   = funcAddr_r;
	assign addressState   = addrState_r;
	assign configured     = configured_r;
	assign suspended      = evt.suspended;

endmodule : udpg_top

// file: design/udpg_map.svh
`ifndef UDPG_MAP_SVH
`define UDPG_MAP_SVH

// Register byte offsets
`define UDPG_OFS_FRAME_NUMBER       8'h00
`define UDPG_OFS_GLOBAL_STATE       8'h04
`define UDPG_OFS_FUNCTION_ADDRESS   8'h08
`define UDPG_OFS_INTERRUPT_ENABLE   8'h10
`define UDPG_OFS_INTERRUPT_DISABLE  8'h14
`define UDPG_OFS_INTERRUPT_MASK     8'h18
`define UDPG_OFS_INTERRUPT_STATUS   8'h1c
`define UDPG_OFS_INTERRUPT_CLEAR    8'h20
`define UDPG_OFS_ENDPOINT_RESET     8'h28
`define UDPG_OFS_EP_CSR_BASE        8'h30
`define UDPG_OFS_EP_FDR_BASE        8'h50

// Frame number register fields
`define UDPG_FRAME_COUNT_FIELD_W              11
`define UDPG_BIT_FRAME_ERROR        16
`define UDPG_BIT_FRAME_GOOD         17

// Global state register fields
`define UDPG_BIT_ADDRESS_STATE      0
`define UDPG_BIT_CONFIGURED         1
`define UDPG_BIT_SEND_RESUME_EN     2
`define UDPG_BIT_RESUME_IN_PROG     3
`define UDPG_BIT_REMOTE_WAKE_DRIVE  4
`define UDPG_RST_GLOBAL_STATE       32'h00000010

// Function address register fields
`define UDPG_FUNCTION_ADDRESS_VALUE_W                 7
`define UDPG_BIT_FUNCTION_ENABLE    8
`define UDPG_RST_FUNCTION_ADDRESS   32'h00000100

// Interrupt bit positions
`define UDPG_NUM_EP                 4
`define UDPG_IRQ_W                  14
`define UDPG_BIT_SUSPEND            8
`define UDPG_BIT_HOST_RESUME        9
`define UDPG_BIT_EXT_RESUME         10
`define UDPG_BIT_FRAME_START        11
`define UDPG_BIT_BUS_RESET_END      12
`define UDPG_BIT_WAKEUP             13
`define UDPG_IRQ_MASKABLE           14'h2f0f
`define UDPG_IRQ_CLEARABLE          14'h3f00
`define UDPG_RST_INTERRUPT_MASK     14'h1200

// Timing
`define UDPG_CLK_MHZ                125
`define UDPG_SUSPEND_IDLE_US        3000

`endif

// file: design/udpg_pkg.sv
package udpg_pkg;

	typedef enum logic {
		UDPG_LINK_ACTIVE,
		UDPG_LINK_SUSPENDED
	} udpg_link_state_t;

	typedef logic [13:0] udpg_irq_vec_t;

endpackage : udpg_pkg

// file: design/udpg_evt_if.sv
`timescale 1ns/100ps

interface udpg_evt_if;
	logic        frameStart;
	logic        frameGood;
	logic        frameError;
	logic [10:0] frameCount;
	logic        suspendEvt;
	logic        hostResumeEvt;
	logic        extResumeEvt;
	logic        suspended;
	logic        sendResumeEnable;

	modport frame_src (output frameStart, frameGood, frameError, frameCount);
	modport susp_src  (output suspendEvt, hostResumeEvt, extResumeEvt, suspended, input sendResumeEnable);
	modport sink      (input frameStart, frameGood, frameError, frameCount,
	                   input suspendEvt, hostResumeEvt, extResumeEvt, suspended, output sendResumeEnable);
endinterface : udpg_evt_if

// file: design/udpg_frame_capture.sv
`timescale 1ns/100ps
`include "udpg_map.svh"

module udpg_frame_capture
	import udpg_pkg::*;
(
	input  wire logic        clk_sys,     // System clock
	input  wire logic        reset_n,     // Async reset
	input  wire logic        sofPid,      // Start-of-frame PID seen
	input  wire logic        sofEop,      // End of start-of-frame packet
	input  wire logic        sofBad,      // Packet error at end of packet
	input  wire logic [10:0] sofFrame,    // Frame field of the packet
	udpg_evt_if.frame_src    evt          // Events to register file
);

	logic [10:0] frameCount_r;
	logic        frameGood_r;
	logic        frameError_r;

	assign evt.frameCount = frameCount_r;
	assign evt.frameGood  = frameGood_r;
	assign evt.frameError = frameError_r;
	assign evt.frameStart = sofPid;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			frameCount_r <= 11'h000;
		end else if (sofEop) begin
			frameCount_r <= sofFrame;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			frameError_r <= 1'b0;
		end else if (sofEop) begin
			frameError_r <= sofBad;
		end else if (sofPid) begin
			frameError_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			frameGood_r <= 1'b0;
		end else if (sofEop) begin
			frameGood_r <= !sofBad;
		end else if (sofPid) begin
			frameGood_r <= 1'b0;
		end
	end

endmodule : udpg_frame_capture

// file: design/udpg_suspend_timer.sv
`timescale 1ns/100ps
`include "udpg_map.svh"

module udpg_suspend_timer
	import udpg_pkg::*;
#(
	parameter int unsigned IDLE_CYCLES = `UDPG_SUSPEND_IDLE_US * `UDPG_CLK_MHZ
)(
	input  wire logic     clk_sys,        // System clock
	input  wire logic     reset_n,        // Async reset
	input  wire logic     busActivityPin, // Line activity, asynchronous
	input  wire logic     sendResumePin,  // External resume request, asynchronous
	udpg_evt_if.susp_src  evt             // Events to register file
);

	logic [1:0]       actSync_r;
	logic [2:0]       resSync_r;
	logic [18:0]      idleCount_r;
	udpg_link_state_t state_r;
	logic             resRise;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			actSync_r <= 2'h0;
			resSync_r <= 3'h0;
		end else begin
			actSync_r <= {actSync_r[0], busActivityPin};
			resSync_r <= {resSync_r[1:0], sendResumePin};
		end
	end

	// Edge taken between second and third stage, never the first
	assign resRise = resSync_r[1] & ~resSync_r[2];

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			idleCount_r <= 19'h00000;
		end else if (actSync_r[1] || state_r == UDPG_LINK_SUSPENDED) begin
			idleCount_r <= 19'h00000;
		end else if (idleCount_r != 19'(IDLE_CYCLES - 1)) begin
			idleCount_r <= idleCount_r + 19'h00001;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= UDPG_LINK_ACTIVE;
		end else begin
			unique case (state_r)
				UDPG_LINK_ACTIVE: begin
					if (evt.suspendEvt) begin
						state_r <= UDPG_LINK_SUSPENDED;
					end
				end
				UDPG_LINK_SUSPENDED: begin
					if (actSync_r[1]) begin
						state_r <= UDPG_LINK_ACTIVE;
					end
				end
			endcase
		end
	end

	assign evt.suspendEvt    = (state_r == UDPG_LINK_ACTIVE) && !actSync_r[1]
	                           && (idleCount_r == 19'(IDLE_CYCLES - 1));
	assign evt.hostResumeEvt = (state_r == UDPG_LINK_SUSPENDED) && actSync_r[1];
	assign evt.extResumeEvt  = (state_r == UDPG_LINK_SUSPENDED) && resRise && evt.sendResumeEnable;
	assign evt.suspended     = (state_r == UDPG_LINK_SUSPENDED);

endmodule : udpg_suspend_timer

// file: dv/udpg_host_model.sv
`timescale 1ns/100ps

module udpg_host_model (
	input  wire logic   clk_sys,        // Clock
	output logic        sofPid,         // Frame PID pulse
	output logic        sofEop,         // Frame end pulse
	output logic        sofBad,         // Frame error
	output logic [10:0] sofFrame,       // Frame field
	output logic        busResetEnd,    // Bus reset end
	output logic        busActivityPin  // Line activity
);
	initial begin
		sofPid         = 1'b0;
		sofEop         = 1'b0;
		sofBad         = 1'b0;
		sofFrame       = 11'h7ff;
		busResetEnd    = 1'b0;
		busActivityPin = 1'b1;
	end

	// PID, then end three cycles on
	task automatic sendSof(input logic [10:0] frame, input logic bad);
		sofPid <= 1'b1;
		@(posedge clk_sys);
		sofPid <= 1'b0;
		repeat (2) @(posedge clk_sys);
		sofEop   <= 1'b1;
		sofFrame <= frame;
		sofBad   <= bad;
		@(posedge clk_sys);
		sofEop   <= 1'b0;
		// Stale field must not look valid later
		sofFrame <= ~frame;
		sofBad   <= ~bad;
	endtask : sendSof

	task automatic busReset();
		busResetEnd <= 1'b1;
		@(posedge clk_sys);
		busResetEnd <= 1'b0;
	endtask : busReset

	// idle line lets the device suspend
	task automatic setIdle(input logic idle);
		busActivityPin <= !idle;
	endtask : setIdle
endmodule : udpg_host_model

// file: dv/udpg_props.sv
`timescale 1ns/100ps

module udpg_props
	import udpg_pkg::*;
#(
	parameter int unsigned IDLE_CYCLES = 20
)(
	input wire logic        clk_sys,        // Clock
	input wire logic        reset_n,        // Reset
	input wire logic [7:0]  regAddr,        // Address
	input wire logic [31:0] regWdata,       // Write data
	input wire logic        regWrite,       // Write strobe
	input wire logic        regRead,        // Read strobe
	input wire logic [31:0] regRdata,       // Read data
	input wire logic        sofEop,         // Frame end
	input wire logic        sofBad,         // Frame error
	input wire logic [10:0] sofFrame,       // Frame field
	input wire logic        busActivityPin, // Line activity
	input wire logic        epCsrSel,       // Status access
	input wire logic        epFdrSel,       // Data access
	input wire logic [1:0]  epIndex,        // Endpoint number
	input wire logic        epWrite,        // Endpoint write
	input wire logic        epRead,         // Endpoint read
	input wire logic [31:0] epWdata,        // Endpoint write data
	input wire logic        functionEnable, // Function on
	input wire logic [6:0]  functionAddr,   // Address value
	input wire logic        addressState,   // Address state
	input wire logic        configured,     // Configured
	input wire logic        kStateDrive,    // K drive
	input wire logic        suspended       // Suspended
);
	logic [31:0] idleCnt_r;

	// Idle run length, restarted by activity
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			idleCnt_r <= 32'h0;
		end else if (busActivityPin) begin
			idleCnt_r <= 32'h0;
		end else begin
			idleCnt_r <= idleCnt_r + 32'h1;
		end
	end

	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	////////////////////////////////////////////////////////////////////////
	chk_rdata_idle: assert property (!regRead |=> regRdata == 32'h0)
		else $error("read data not zero outside read");
	chk_wo_reads_zero: assert property (
		regRead && (regAddr == 8'h10 || regAddr == 8'h14 || regAddr == 8'h20) |=> regRdata == 32'h0)
		else $error("write-only register read not zero");
	chk_mask_set: assert property (
		regWrite && regAddr == 8'h10 && regWdata[11] ##2 regRead && regAddr == 8'h18 |=> regRdata[11])
		else $error("enable write did not set mask");
	chk_mask_clear: assert property (
		regWrite && regAddr == 8'h14 && regWdata[11] ##2 regRead && regAddr == 8'h18 |=> !regRdata[11])
		else $error("disable write did not clear mask");
	chk_frame_capture: assert property (
		sofEop ##1 (regRead && regAddr == 8'h00) |=> regRdata[10:0] == $past(sofFrame, 2)
		&& regRdata[16] == $past(sofBad, 2) && regRdata[17] == !$past(sofBad, 2))
		else $error("frame register wrong after packet end");
	chk_addr_set: assert property (regWrite && regAddr == 8'h04 && regWdata[0] |=> addressState)
		else $error("address state not entered");
	chk_addr_hold: assert property (addressState |=> addressState)
		else $error("address state left without reset");
	chk_config_write: assert property (
		regWrite && regAddr == 8'h04 |=> configured == $past(regWdata[1]))
		else $error("configured state not written");
	chk_kstate_drive: assert property (
		regWrite && regAddr == 8'h04 |=> kStateDrive == ($past(regWdata[4]) && $past(regWdata[2])))
		else $error("K drive not gated by enable");
	chk_faddr_write: assert property (
		regWrite && regAddr == 8'h08 |=> functionAddr == $past(regWdata[6:0])
		&& functionEnable == $past(regWdata[8]))
		else $error("function address register not written");
	chk_ep_csr_dec: assert property (
		regWrite && regAddr[7:4] == 4'h3 && regAddr[1:0] == 2'h0
		|-> epWrite && epCsrSel && !epFdrSel && epIndex == regAddr[3:2])
		else $error("endpoint status decode wrong");
	chk_ep_fdr_dec: assert property (
		regRead && regAddr[7:4] == 4'h5 && regAddr[1:0] == 2'h0
		|-> epRead && epFdrSel && !epCsrSel && epIndex == regAddr[3:2])
		else $error("endpoint data decode wrong");
	chk_ep_wdata: assert property (epWrite |-> epWdata == regWdata)
		else $error("endpoint write data wrong");
	chk_suspend_due: assert property (idleCnt_r == IDLE_CYCLES + 32'd5 |-> suspended)
		else $error("no suspend after idle time");
endmodule : udpg_props

bind udpg_top udpg_props #(.IDLE_CYCLES(IDLE_CYCLES)) u_udpg_props (.clk_sys, .reset_n, .regAddr,
	.regWdata, .regWrite, .regRead, .regRdata, .sofEop, .sofBad, .sofFrame, .busActivityPin, .epCsrSel,
	.epFdrSel, .epIndex, .epWrite, .epRead, .epWdata, .functionEnable, .functionAddr, .addressState, .configured,
	.kStateDrive, .suspended);

// file: dv/tb_top.sv
`timescale 1ns/100ps

module tb_top;
	localparam int unsigned IDLE = 20;
	logic        clk_sys, reset_n, regWrite, regRead, rdLast, sendResumePin;
	logic        sofPid, sofEop, sofBad, busResetEnd, busActivityPin, irq;
	logic        epCsrSel, epFdrSel, epWrite, epRead, functionEnable, addressState;
	logic        configured, kStateDrive, suspended;
	logic [7:0]  regAddr;
	logic [31:0] regWdata, regRdata, epRdata, d;
	logic [10:0] sofFrame, fr;
	logic [6:0]  functionAddr, fa;
	logic [3:0]  epIrq;
	logic [1:0]  epIndex;
	logic [31:0] expQ[$], mskQ[$];
	logic [7:0]  rstAddr[8] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h10, 8'h14, 8'h20, 8'h74};
	logic [31:0] rstVal[8]  = '{32'h0, 32'h10, 32'h100, 32'h1200, 32'h0, 32'h0, 32'h0, 32'h0};
	int          irqBit[9]  = '{0, 1, 2, 3, 8, 9, 10, 11, 13};
	int          failures = 0, compares = 0, seed = 2720;

	udpg_top #(.IDLE_CYCLES(IDLE)) u_udpg_top (.clk_sys, .reset_n, .regAddr, .regWdata, .regWrite,
		.regRead, .regRdata, .sofPid, .sofEop, .sofBad, .sofFrame, .busResetEnd, .busActivityPin,
		.sendResumePin, .epIrq, .epRdata, .epCsrSel, .epFdrSel, .epIndex, .epWrite, .epRead,
		.epWdata(), .epReset(), .functionEnable, .functionAddr, .addressState, .configured,
		.kStateDrive, .suspended, .irq);
	udpg_host_model u_udpg_host_model (.clk_sys, .sofPid, .sofEop, .sofBad, .sofFrame, .busResetEnd,
		.busActivityPin);

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
		compares++;
		if (((got ^ exp) & msk) !== 32'h0) begin
			failures++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic cmpPin(input logic got, input logic exp);
		check({31'h0, got}, {31'h0, exp}, 32'h1);
	endtask : cmpPin

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		regAddr  <= a;
		regWdata <= v;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
		@(posedge clk_sys);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		regAddr <= a;
		regRead <= 1'b1;
		expQ.push_back(e);
		mskQ.push_back(m);
		@(posedge clk_sys);
		regRead <= 1'b0;
		@(posedge clk_sys);
	endtask : rd

	task automatic close_out();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out

	// Read data stands only in the cycle after the strobe
	always @(posedge clk_sys) rdLast <= regRead;
	always @(negedge clk_sys) begin
		if (rdLast === 1'b1) begin
			check(regRdata, expQ.pop_front(), mskQ.pop_front());
		end
	end

	initial begin
		repeat (4000) @(posedge clk_sys);
		failures++;
		close_out();
	end

	initial begin
		{reset_n, regWrite, regRead, sendResumePin} = 4'h0;
		{regAddr, regWdata, epRdata, epIrq} = 76'h0;
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		foreach (rstAddr[i]) rd(rstAddr[i], rstVal[i], 32'hffffffff);
		u_udpg_host_model.busReset();
		rd(8'h1c, 32'h3000, 32'h3000);
		wr(8'h20, 32'h3f00);
		fa = 7'($random(seed));
		wr(8'h08, {23'h0, 1'b1, 1'b0, fa});
		rd(8'h08, {23'h0, 1'b1, 1'b0, fa}, 32'h1ff);
		wr(8'h04, 32'h1);
		wr(8'h04, 32'h3);
		rd(8'h04, 32'h3, 32'h1f);
		wr(8'h04, 32'h0);
		rd(8'h04, 32'h1, 32'h1f);
		wr(8'h04, 32'h14);
		#1 cmpPin(kStateDrive, 1'b1);
		wr(8'h04, 32'h10);
		#1 cmpPin(kStateDrive, 1'b0);
		wr(8'h08, {25'h0, fa});
		#1 cmpPin(functionEnable, 1'b0);
		check({25'h0, functionAddr}, {25'h0, fa}, 32'h7f);
		wr(8'h14, 32'h2f0f);
		foreach (irqBit[i]) begin
			wr(8'h10, 32'h1 << irqBit[i]);
			rd(8'h18, (32'h1 << irqBit[i]) | 32'h1000, 32'h3f0f);
			wr(8'h14, 32'h1 << irqBit[i]);
			rd(8'h18, 32'h1000, 32'h3f0f);
		end
		wr(8'h10, 32'h4);
		wr(8'h14, 32'h0);
		rd(8'h18, 32'h1004, 32'h3f0f);
		epIrq <= 4'h4;
		@(posedge clk_sys);
		#1 cmpPin(irq, 1'b1);
		epIrq <= 4'h8;
		@(posedge clk_sys);
		#1 cmpPin(irq, 1'b0);
		epIrq <= 4'h0;
		for (int i = 0; i < 4; i++) begin
			d = $random(seed);
			epRdata <= d;
			rd(8'h50 + 8'(i * 4), d, 32'hffffffff);
			wr(8'h30 + 8'(i * 4), d);
		end
		rd(8'h70, 32'h0, 32'hffffffff);
		wr(8'h10, 32'h800);
		fr = 11'($random(seed));
		u_udpg_host_model.sendSof(fr, 1'b0);
		rd(8'h00, {14'h0, 2'b10, 5'h0, fr}, 32'h307ff);
		wr(8'h20, 32'h800);
		#1 cmpPin(irq, 1'b0);
		fork
			u_udpg_host_model.sendSof(~fr, 1'b1);
			begin
				@(posedge clk_sys);
				#1 cmpPin(irq, 1'b1);
				rd(8'h00, {21'h0, fr}, 32'h307ff);
			end
		join
		rd(8'h00, {14'h0, 2'b01, 5'h0, ~fr}, 32'h307ff);
		wr(8'h20, 32'h3f00);
		wr(8'h04, 32'h15);
		u_udpg_host_model.setIdle(1'b1);
		for (int n = 0; n < 60 && suspended !== 1'b1; n++) @(posedge clk_sys);
		// Stay idle past the checker's suspend bound
		repeat (8) @(posedge clk_sys);
		#1 cmpPin(suspended, 1'b1);
		rd(8'h1c, 32'h100, 32'h3f00);
		sendResumePin <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rd(8'h1c, 32'h2500, 32'h3f00);
		u_udpg_host_model.setIdle(1'b0);
		for (int n = 0; n < 20 && suspended !== 1'b0; n++) @(posedge clk_sys);
		repeat (2) @(posedge clk_sys);
		rd(8'h1c, 32'h2700, 32'h3f00);
		rd(8'h04, 32'h1d, 32'h1f);
		wr(8'h04, 32'h5);
		rd(8'h04, 32'h5, 32'h1f);
		sendResumePin <= 1'b0;
		repeat (3) @(posedge clk_sys);
		close_out();
	end
endmodule : tb_top
